/* bench/adc_config_serial_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_config_serial_port_test;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic [1:0] cmd_len = 2'h0;
  logic [12:0] cmd_addr = 13'h0000;
  logic cmd_lsb_first = 1'h0;
  logic stall_req = 1'h0;
  logic stream_stop = 1'h0;
  logic wr_valid = 1'h0;
  logic [7:0] wr_data = 8'h00;
  logic cmd_ready, done, wr_ready, rd_valid, reg_wr_pulse, secondary_en;
  logic [7:0] rd_data, reg_wr_data;
  logic [12:0] reg_wr_addr;
  logic [7:0] mem [64];
  logic [7:0] tx [8];
  logic [12:0] got_a [$];
  logic [7:0] got_d [$];
  logic lsb_mode = 1'h0;
  int fail_count = 0;
  int num_checks = 0;

  // The two ends face each other across the link.
  cfgsp_if cfgsp_if_inst ();
  cfgsp_ctrl cfgsp_ctrl_inst (.clk_sys, .reset, .ce(1'h1), .cmd_valid, .cmd_read, .cmd_len,
    .cmd_addr, .cmd_lsb_first, .cmd_ready, .stall_req, .stream_stop, .done, .wr_valid,
    .wr_data, .wr_ready, .rd_valid, .rd_data, .link(cfgsp_if_inst));
  cfgsp_dev cfgsp_dev_inst (.clk_sys, .reset, .ce(1'h1), .link(cfgsp_if_inst), .reg_wr_pulse,
    .reg_wr_addr, .reg_wr_data, .secondary_en);
  cfgsp_asserts cfgsp_asserts_inst (.clk_sys, .reset, .sclk(cfgsp_if_inst.sclk),
    .cs_n(cfgsp_if_inst.cs_n), .sdio_h_o(cfgsp_if_inst.sdio_h_o),
    .sdio_h_oe(cfgsp_if_inst.sdio_h_oe), .sdio_d_o(cfgsp_if_inst.sdio_d_o),
    .sdio_d_oe(cfgsp_if_inst.sdio_d_oe), .sdio(cfgsp_if_inst.sdio));

  // Makes the system clock.
  always #2 clk_sys = ~clk_sys;

  // Collects the byte writes that the device reports.
  always @(posedge clk_sys)
  begin
    if (reg_wr_pulse === 1'h1)
    begin
      got_a.push_back(reg_wr_addr);
      got_d.push_back(reg_wr_data);
    end
  end

  // Compares a seen value with the expected one.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Loads the bytes that the next write frame sends.
  task automatic fill(input logic [7:0] base);
    for (int i = 0; i < 8; i++)
      tx[i] = base ^ 8'(i * 8'h25);
  endtask

  // Runs one frame and judges the bytes that cross it.
  task automatic do_cmd(input logic rd, input logic [1:0] len, input logic [12:0] addr,
    input int nb, input logic stall);
    int k;
    int w;
    int st;
    int t;
    logic [12:0] a;
    k = 0;
    w = 0;
    st = 0;
    a = addr;
    got_a.delete();
    got_d.delete();
    chk(16'(cmd_ready), 16'h0001);
    cmd_read = rd;
    cmd_len = len;
    cmd_addr = addr;
    cmd_lsb_first = lsb_mode;
    cmd_valid = 1'h1;
    wr_valid = ~rd;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'h0;
    for (t = 0; t < 5000; t++)
    begin
      wr_data = tx[k];
      if (wr_ready === 1'h1)
        k++;
      if (rd_valid === 1'h1)
      begin
        chk(16'(rd_data), 16'(mem[a[5:0]]));
        a = lsb_mode ? a + 13'h0001 : a - 13'h0001;
        w++;
      end
      stream_stop = (k >= nb);
      if (stall && k == 1 && st == 0)
        stall_req = 1'h1;
      if (stall_req === 1'h1 && cfgsp_if_inst.cs_n === 1'h1)
        st++;
      if (st == 8 && stall_req === 1'h1)
      begin
        chk(16'(secondary_en), 16'h0001);
        stall_req = 1'h0;
      end
      if (done === 1'h1)
        break;
      @(posedge clk_sys);
      #1;
    end
    if (t == 5000)
    begin
      fail_count++;
      give_verdict();
    end
    wr_valid = 1'h0;
    stream_stop = 1'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(16'(cfgsp_if_inst.cs_n), 16'h0001);
    chk(16'(cfgsp_if_inst.sclk), 16'h0000);
    if (rd)
    begin
      chk(16'(w), 16'(nb));
      chk(16'(got_a.size()), 16'h0000);
    end
    else
    begin
      chk(16'(got_a.size()), 16'(nb));
      for (int i = 0; i < got_a.size(); i++)
      begin
        chk(16'(got_a[i]), 16'(a));
        chk(16'(got_d[i]), 16'(tx[i]));
        mem[a[5:0]] = tx[i];
        if (a == cfgsp_pkg::CFG_ADDR)
          lsb_mode = tx[i][cfgsp_pkg::CFG_LSB_POS];
        a = lsb_mode ? a + 13'h0001 : a - 13'h0001;
      end
    end
  endtask

  // Writes of one, two and three bytes, each read back.
  task automatic sc_counted();
    for (int n = 0; n < 3; n++)
    begin
      fill(8'h3c + 8'(n));
      do_cmd(1'h0, 2'(n), 13'h0012 + 13'(n * 8), n + 1, 1'h0);
      do_cmd(1'h1, 2'(n), 13'h0012 + 13'(n * 8), n + 1, 1'h0);
    end
  endtask

  // Select goes high between bytes and the frame resumes.
  task automatic sc_stall();
    fill(8'hc3);
    do_cmd(1'h0, 2'h2, 13'h0030, 3, 1'h1);
    do_cmd(1'h1, 2'h2, 13'h0030, 3, 1'h0);
  endtask

  // Least significant bit first with upward addresses, then back.
  task automatic sc_lsb();
    tx[0] = 8'h40;
    do_cmd(1'h0, 2'h0, cfgsp_pkg::CFG_ADDR, 1, 1'h0);
    chk(16'(lsb_mode), 16'h0001);
    fill(8'h81);
    do_cmd(1'h0, 2'h1, 13'h0028, 2, 1'h0);
    do_cmd(1'h1, 2'h1, 13'h0028, 2, 1'h0);
    tx[0] = 8'h00;
    do_cmd(1'h0, 2'h0, cfgsp_pkg::CFG_ADDR, 1, 1'h0);
  endtask

  // Streaming write of four bytes, the first three read back by a counted frame.
  task automatic sc_stream();
    fill(8'h6e);
    do_cmd(1'h0, cfgsp_pkg::LEN_STREAM, 13'h003f, 4, 1'h0);
    chk(16'(got_a.size()), 16'h0004);
    do_cmd(1'h1, 2'h2, 13'h003f, 3, 1'h0);
  endtask

  // Resets the ends, then works through the scenarios.
  initial
  begin
    int w;
    w = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    reset = 1'h0;
    // Waits until the controller has clocked the device end out of reset.
    while (cmd_ready !== 1'h1 && w < 200)
    begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    if (w == 200)
    begin
      fail_count++;
      give_verdict();
    end
    sc_counted();
    sc_stall();
    sc_lsb();
    sc_stream();
    give_verdict();
  end
endmodule
`default_nettype wire

/* bench/cfgsp_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgsp_asserts (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Link wires.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_h_o,
  input wire logic sdio_h_oe,
  input wire logic sdio_d_o,
  input wire logic sdio_d_oe,
  input wire logic sdio
);
  logic sclk_q;
  logic cs_q;
  logic [7:0] rise_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Counts serial clock rises since select last fell.
  always_ff @(posedge clk_sys)
  begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    if (reset || (cs_q && !cs_n))
      rise_q <= 8'h00;
    else if (sclk && !sclk_q && !cs_n)
      rise_q <= rise_q + 8'h01;
  end

  // A high half of the serial clock lasts four system cycles at least.
  sequence s_high_half;
    sclk [*4];
  endsequence
  sequence s_low_start;
    !$rose(sclk) ##1 !$rose(sclk);
  endsequence

  // Each end drives the data line only while the other has let it go.
  a_single_driver: assert property (!(sdio_h_oe && sdio_d_oe))
    else $error("both ends drive the data line");
  a_dev_release: assert property (cs_n |-> !sdio_d_oe)
    else $error("device drives while deselected");
  a_host_release: assert property (cs_n |-> !sdio_h_oe)
    else $error("controller drives while deselected");
  a_frame_start: assert property ($fell(cs_n) |-> s_low_start)
    else $error("serial clock rose as select fell");
  a_half_period: assert property ($rose(sclk) && !cs_n |-> s_high_half)
    else $error("serial clock high half too short");
  a_turn_after: assert property ($rose(sdio_d_oe) |-> rise_q == 8'h10 && !sclk)
    else $error("read turnaround not after sixteen bits");
  a_hold_drive: assert property ($fell(sdio_d_oe) |-> cs_n || rise_q[2:0] == 3'h0)
    else $error("device let go of the line inside a byte");
  a_whole_bytes: assert property ($rose(cs_n) |-> rise_q[2:0] == 3'h0)
    else $error("frame ended inside a byte");
endmodule
`default_nettype wire

/* verilog/cfgsp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgsp_ctrl (
  // System clock, reset and enable.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Command request.
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [1:0] cmd_len,
  input wire logic [12:0] cmd_addr,
  input wire logic cmd_lsb_first,
  output logic cmd_ready,
  // Frame control.
  input wire logic stall_req,
  input wire logic stream_stop,
  output logic done,
  // Write bytes.
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // Read bytes.
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Serial link.
  cfgsp_if.ctrl link
);

  typedef enum logic [2:0] {H_IDLE, H_INSTR, H_LOAD, H_DATA, H_STALL, H_END} cfgsp_hst_t;

  typedef struct packed {
    cfgsp_hst_t st;
    logic [2:0] div;
    logic sclk;
    logic cs_n;
    logic sdo;
    logic oe;
    logic [15:0] sh;
    logic [3:0] bit_cnt;
    logic rw;
    logic [1:0] len;
    logic [1:0] left;
    logic lsb;
    logic [7:0] rx;
    logic [1:0] sdi_sync;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic done;
    logic [6:0] rst_cnt;
  } cfgsp_host_t;

  cfgsp_host_t q;
  cfgsp_host_t d;

  // Divider, frame sequencer and shifters of the controller end.
  always_comb
  begin
    logic tick;
    logic more;
    logic [7:0] rx;
    tick = q.div == cfgsp_pkg::SCLK_HALF_LAST;
    more = 1'h0;
    rx = 8'h00;
    d = q;
    d.wr_ready = 1'h0;
    d.rd_valid = 1'h0;
    d.done = 1'h0;
    d.sdi_sync = {q.sdi_sync[0], link.sdio};
    d.div = tick ? 3'h0 : q.div + 3'h1;
    if (reset)
    begin
      d = '0;
      d.st = H_IDLE;
      d.cs_n = 1'h1;
      d.rst_cnt = cfgsp_pkg::CTRL_RST_HOLD;
    end
    else if (!ce)
      d = q;
    else if (q.rst_cnt != 7'h00)
    begin
      // Clock runs with select high after reset so the device end leaves its reset.
      d.rst_cnt = q.rst_cnt - 7'h01;
      d.sclk = tick ? ~q.sclk : q.sclk;
    end
    else
    begin
      unique case (q.st)
        H_IDLE:
        begin
          d.sclk = 1'h0;
          if (cmd_valid)
          begin
            // Instruction goes out MSB first: rw, length, address.
            d.sh = {cmd_read, cmd_len, cmd_addr};
            d.rw = cmd_read;
            d.len = cmd_len;
            d.left = cmd_len;
            d.lsb = cmd_lsb_first;
            d.cs_n = 1'h0;
            d.oe = 1'h1;
            d.sdo = cmd_read;
            d.bit_cnt = 4'h0;
            d.div = 3'h0;
            d.st = H_INSTR;
          end
        end
        H_INSTR:
        begin
          if (tick && !q.sclk)
            d.sclk = 1'h1;
          else if (tick)
          begin
            d.sclk = 1'h0;
            d.sh = {q.sh[14:0], 1'h0};
            d.sdo = q.sh[14];
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == cfgsp_pkg::INSTR_LAST)
            begin
              d.sclk = 1'h1;
              d.sdo = q.sdo;
              d.bit_cnt = 4'h0;
              d.st = H_LOAD;
            end
          end
        end
        H_LOAD:
        begin
          if (tick)
          begin
            if (stall_req || (!q.rw && !wr_valid))
            begin
              d.cs_n = 1'h1;
              d.oe = 1'h0;
              d.st = H_STALL;
            end
            else
            begin
              d.sclk = 1'h0;
              d.st = H_DATA;
              d.oe = !q.rw;
              if (!q.rw)
              begin
                d.wr_ready = 1'h1;
                d.sh = {8'h00, wr_data};
                d.sdo = q.lsb ? wr_data[0] : wr_data[7];
              end
            end
          end
        end
        H_STALL:
        begin
          if (tick && !stall_req && (q.rw || wr_valid))
          begin
            d.cs_n = 1'h0;
            d.st = H_LOAD;
          end
        end
        H_DATA:
        begin
          if (tick && !q.sclk)
          begin
            d.sclk = 1'h1;
            rx = cfgsp_pkg::shift_in(q.rx, q.sdi_sync[1], q.lsb);
            d.rx = rx;
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == cfgsp_pkg::BYTE_LAST)
            begin
              d.bit_cnt = 4'h0;
              d.rd_valid = q.rw;
              if (q.len == cfgsp_pkg::LEN_STREAM)
                more = !stream_stop;
              else
                more = q.left != 2'h0;
              d.left = q.left - 2'h1;
              d.st = more ? H_LOAD : H_END;
            end
          end
          else if (tick)
          begin
            d.sclk = 1'h0;
            if (!q.rw)
            begin
              d.sh = {8'h00, q.lsb ? {1'h0, q.sh[7:1]} : {q.sh[6:0], 1'h0}};
              d.sdo = q.lsb ? q.sh[1] : q.sh[6];
            end
          end
        end
        H_END:
        begin
          if (tick && q.sclk)
            d.sclk = 1'h0;
          else if (tick)
          begin
            d.cs_n = 1'h1;
            d.oe = 1'h0;
            d.done = 1'h1;
            d.st = H_IDLE;
          end
        end
        default:
          d.st = H_IDLE;
      endcase
    end
    d.cmd_ready = d.st == H_IDLE && d.rst_cnt == 7'h00 && !reset;
  end

  // Registers the whole controller state.
  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign cmd_ready = q.cmd_ready;
  assign done = q.done;
  assign wr_ready = q.wr_ready;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rx;
  assign link.sclk = q.sclk;
  assign link.cs_n = q.cs_n;
  assign link.sdio_h_o = q.sdo;
  assign link.sdio_h_oe = q.oe;
endmodule
`default_nettype wire

/* verilog/cfgsp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module cfgsp_dev (
  // System side clock, reset and enable.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Serial link.
  cfgsp_if.dev link,
  // Byte writes reported to the system side.
  output logic reg_wr_pulse,
  output logic [12:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  // Secondary pin functions while select stays high.
  output logic secondary_en
);

  typedef struct packed {
    logic [1:0] rst_sync;
    cfgsp_pkg::cfgsp_lphase_t ph;
    logic [3:0] bit_cnt;
    logic [15:0] instr;
    logic rw;
    logic [1:0] len;
    logic [1:0] left;
    logic [12:0] addr;
    logic [7:0] rx;
    logic lsb;
    logic wr_tgl;
    logic [12:0] wr_addr;
    logic [7:0] wr_data;
  } cfgsp_dlink_t;

  typedef struct packed {
    logic [1:0] tgl_sync;
    logic tgl_seen;
    logic wr_pulse;
    logic [12:0] addr;
    logic [7:0] data;
    logic [1:0] cs_sync;
    logic sec_en;
    logic [6:0] rst_cnt;
    logic rst_out;
  } cfgsp_dsys_t;

  cfgsp_dlink_t lq;
  cfgsp_dlink_t ld;
  cfgsp_dsys_t sq;
  cfgsp_dsys_t sd;
  logic cs_gap_q;
  logic sdo_q;
  logic oe_q;
  logic mem_we;
  logic [7:0] mem [cfgsp_pkg::REG_DEPTH];
  logic [7:0] rd_byte;
  logic [2:0] tx_pos;

  // Flags whether a register address lies inside the byte store.
  function automatic logic in_range(input logic [12:0] a);
    in_range = a < 13'(cfgsp_pkg::REG_DEPTH);
  endfunction

  // Marks that select went high since the last clock edge; reads the pin asynchronously.
  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
      cs_gap_q <= 1'h1;
    else
      cs_gap_q <= 1'h0;
  end

  // Link-side frame decoder, sampling the data line on rising clock edges.
  always_comb
  begin
    cfgsp_pkg::cfgsp_lphase_t ph_now;
    logic resume;
    logic [15:0] ins;
    logic [7:0] rx;
    ph_now = lq.ph;
    resume = 1'h0;
    ins = 16'h0000;
    rx = 8'h00;
    mem_we = 1'h0;
    ld = lq;
    ld.rst_sync = {lq.rst_sync[0], sq.rst_out};
    if (lq.rst_sync[1])
    begin
      ld.ph = cfgsp_pkg::LP_IDLE;
      ld.bit_cnt = 4'h0;
      ld.wr_tgl = 1'h0;
      ld.lsb = cfgsp_pkg::CFG_LSB_RESET;
    end
    else if (!link.cs_n)
    begin
      // A gap at a byte boundary of a counted frame is a stall; otherwise restart.
      resume = lq.ph == cfgsp_pkg::LP_DATA && lq.bit_cnt == 4'h0 &&
               lq.len != cfgsp_pkg::LEN_STREAM;
      if (cs_gap_q && !resume)
        ph_now = cfgsp_pkg::LP_IDLE;
      unique case (ph_now)
        cfgsp_pkg::LP_IDLE:
        begin
          ld.instr = {15'h0000, link.sdio};
          ld.bit_cnt = 4'h1;
          ld.ph = cfgsp_pkg::LP_INSTR;
        end
        cfgsp_pkg::LP_INSTR:
        begin
          ins = {lq.instr[14:0], link.sdio};
          ld.instr = ins;
          ld.bit_cnt = lq.bit_cnt + 4'h1;
          if (lq.bit_cnt == cfgsp_pkg::INSTR_LAST)
          begin
            ld.ph = cfgsp_pkg::LP_DATA;
            ld.bit_cnt = 4'h0;
            ld.rw = ins[cfgsp_pkg::RW_POS];
            ld.len = {ins[cfgsp_pkg::LEN_HI_POS], ins[cfgsp_pkg::LEN_LO_POS]};
            ld.left = ld.len;
            ld.addr = ins[12:0];
          end
        end
        cfgsp_pkg::LP_DATA:
        begin
          rx = cfgsp_pkg::shift_in(lq.rx, link.sdio, lq.lsb);
          ld.rx = rx;
          ld.bit_cnt = lq.bit_cnt + 4'h1;
          if (lq.bit_cnt == cfgsp_pkg::BYTE_LAST)
          begin
            ld.bit_cnt = 4'h0;
            if (!lq.rw)
            begin
              mem_we = in_range(lq.addr);
              ld.wr_tgl = ~lq.wr_tgl;
              ld.wr_addr = lq.addr;
              ld.wr_data = rx;
              if (lq.addr == cfgsp_pkg::CFG_ADDR)
                ld.lsb = rx[cfgsp_pkg::CFG_LSB_POS];
            end
            ld.addr = cfgsp_pkg::next_addr(lq.addr, lq.lsb);
            if (lq.len != cfgsp_pkg::LEN_STREAM)
            begin
              if (lq.left == 2'h0)
                ld.ph = cfgsp_pkg::LP_IDLE;
              else
                ld.left = lq.left - 2'h1;
            end
          end
        end
        default:
          ld.ph = cfgsp_pkg::LP_IDLE;
      endcase
    end
  end

  // Registers the link-side state on the serial clock.
  always_ff @(posedge link.sclk)
  begin
    lq <= ld;
  end

  // Byte store written at the end of each in-range write byte; cleared by the link reset.
  always_ff @(posedge link.sclk)
  begin
    if (lq.rst_sync[1])
    begin
      for (int i = 0; i < cfgsp_pkg::REG_DEPTH; i++)
        mem[i] <= 8'h00;
    end
    else if (mem_we)
      mem[lq.addr[cfgsp_pkg::REG_IDX_W-1:0]] <= ld.rx;
  end

  // Byte to return and the position of the next bit in the chosen order.
  assign rd_byte = in_range(lq.addr) ? mem[lq.addr[cfgsp_pkg::REG_IDX_W-1:0]] : 8'h00;
  assign tx_pos = lq.lsb ? lq.bit_cnt[2:0] : 3'h7 - lq.bit_cnt[2:0];

  // Drives read data on falling edges; select high releases the line at once.
  always_ff @(negedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      oe_q <= 1'h0;
      sdo_q <= 1'h0;
    end
    else if (lq.ph == cfgsp_pkg::LP_DATA && lq.rw)
    begin
      oe_q <= 1'h1;
      sdo_q <= rd_byte[tx_pos];
    end
    else
    begin
      oe_q <= 1'h0;
      sdo_q <= 1'h0;
    end
  end

  assign link.sdio_d_o = sdo_q;
  assign link.sdio_d_oe = oe_q;

  // System side: catches write toggles and the select level through two flops.
  always_comb
  begin
    sd = sq;
    sd.wr_pulse = 1'h0;
    if (reset)
    begin
      sd = '0;
      sd.rst_cnt = cfgsp_pkg::DEV_RST_HOLD;
      sd.rst_out = 1'h1;
    end
    else if (ce)
    begin
      sd.tgl_sync = {sq.tgl_sync[0], lq.wr_tgl};
      sd.cs_sync = {sq.cs_sync[0], link.cs_n};
      sd.sec_en = sq.cs_sync[1];
      // Link reset is held long enough for several serial clock edges to carry it.
      sd.rst_out = sq.rst_cnt != 7'h00;
      if (sq.rst_cnt != 7'h00)
        sd.rst_cnt = sq.rst_cnt - 7'h01;
      // While the link side clears, its toggle is followed without a report.
      if (sq.rst_out)
        sd.tgl_seen = sq.tgl_sync[1];
      else if (sq.tgl_sync[1] != sq.tgl_seen)
      begin
        sd.tgl_seen = sq.tgl_sync[1];
        sd.wr_pulse = 1'h1;
        sd.addr = lq.wr_addr;
        sd.data = lq.wr_data;
      end
    end
  end

  // Registers the system-side state.
  always_ff @(posedge clk_sys)
  begin
    sq <= sd;
  end

  assign reg_wr_pulse = sq.wr_pulse;
  assign reg_wr_addr = sq.addr;
  assign reg_wr_data = sq.data;
  assign secondary_en = sq.sec_en;
endmodule
`default_nettype wire

/* verilog/cfgsp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cfgsp_if;
  // Link wires made by the controller end.
  logic sclk;
  logic cs_n;
  // Shared data line, one driver pair per end.
  logic sdio_h_o;
  logic sdio_h_oe;
  logic sdio_d_o;
  logic sdio_d_oe;
  logic sdio;

  // Wire level resolved from the enables; a released line pulls high.
  assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'h1);

  modport ctrl (output sclk, output cs_n, output sdio_h_o, output sdio_h_oe, input sdio);
  modport dev (input sclk, input cs_n, input sdio, output sdio_d_o, output sdio_d_oe);
endinterface
`default_nettype wire

/* verilog/cfgsp_pkg.sv */
`default_nettype none
package cfgsp_pkg;
  // Frame layout of the instruction word.
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 13;
  localparam int RW_POS = 15;
  localparam int LEN_HI_POS = 14;
  localparam int LEN_LO_POS = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // Port configuration byte and its bit-order field.
  localparam logic [12:0] CFG_ADDR = 13'h0000;
  localparam int CFG_LSB_POS = 6;
  localparam logic CFG_LSB_RESET = 1'h0;
  // Byte store held at the device end.
  localparam int REG_DEPTH = 64;
  localparam int REG_IDX_W = 6;
  // Serial clock made by the controller end.
  localparam int CLK_SYS_NS = 4;
  localparam int SCLK_HALF_NS = 16;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);
  // Reset stretch in clk_sys cycles. The controller keeps clocking longer than the device
  // holds its link reset, so the link-side synchroniser clears before the first frame.
  localparam logic [6:0] DEV_RST_HOLD = 7'h28;
  localparam logic [6:0] CTRL_RST_HOLD = 7'h50;

  typedef enum logic [1:0] {LP_IDLE, LP_INSTR, LP_DATA} cfgsp_lphase_t;

  // Shifts one serial bit into a byte in the selected order.
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic bit_in,
                                          input logic lsb);
    shift_in = lsb ? {bit_in, b[7:1]} : {b[6:0], bit_in};
  endfunction

  // Next address of a multi-byte transfer: down when MSB first, up when LSB first.
  function automatic logic [12:0] next_addr(input logic [12:0] a, input logic lsb);
    next_addr = lsb ? a + 13'h0001 : a - 13'h0001;
  endfunction
endpackage
`default_nettype wire
